// file: hdl/mcr_regs.vh
// Register offsets, field positions and reset values of the monitor bank
`ifndef MCR_REGS_VH
`define MCR_REGS_VH

`define MCR_ADDR_GEN 8'h14
`define MCR_ADDR_DACCFG 8'h15
`define MCR_ADDR_PULLDN 8'h16
`define MCR_ADDR_HIEN 8'h17
`define MCR_ADDR_LOEN 8'h18
`define MCR_ADDR_CHEN1 8'h19
`define MCR_ADDR_CHEN2 8'h1A
`define MCR_ADDR_TEMPEN 8'h1B
`define MCR_ADDR_TRIG 8'h1C
`define MCR_ADDR_RES_BASE 8'h20
`define MCR_ADDR_RES_LAST 8'h30
`define MCR_ADDR_HLIM_BASE 8'h40
`define MCR_ADDR_LLIM_BASE 8'h46
`define MCR_ADDR_LIM_LAST 8'h4B
`define MCR_ADDR_REFMODE 8'h66
`define MCR_ADDR_CODE_BASE 8'h80
`define MCR_ADDR_CODE_LAST 8'h8B
`define MCR_ADDR_BCAST 8'h90

`define MCR_GEN_RST 7
`define MCR_GEN_TOD 2
`define MCR_GEN_LOCK 1
`define MCR_GEN_START 0
`define MCR_DAC_GROUP 2
`define MCR_DAC_LEVEL 1
`define MCR_DAC_OFF 0
`define MCR_REF_ADC_EXT 2
`define MCR_REF_DAC_EXT 1

`define MCR_RST_GEN 8'h00
`define MCR_RST_DACCFG 8'h03
`define MCR_RST_PULLDN 8'hFF
`define MCR_RST_IRQEN 8'h00
`define MCR_RST_CHEN 8'h00
`define MCR_RST_REFMODE 8'h07
`define MCR_RST_RESULT 12'h000
`define MCR_RST_HLIM 12'hFFF
`define MCR_RST_LLIM 12'h000
`define MCR_RST_CODE 12'h000

`define MCR_IRQEN_MASK 8'h3F
`define MCR_TEMPEN_MASK 8'h01
`define MCR_REF_MASK 8'h07
`define MCR_DACCFG_MASK 8'h07
`define MCR_GEN_MASK 8'h07

`endif

// file: hdl/mcr_seq.v
// Conversion sequencer: walks the enabled channels once or repeatedly
module mcr_seq #(
	parameter NCH = 17,
	parameter CW = 5
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire soft_clr_i,
	// Control
	input wire single_i,
	input wire cont_i,
	input wire [NCH-1:0] chan_en_i,
	// Converter handshake
	output reg adc_start_o,
	output reg [CW-1:0] adc_chan_o,
	input wire adc_done_i,
	input wire [11:0] adc_data_i,
	// Result write
	output reg res_we_o,
	output reg [CW-1:0] res_idx_o,
	output reg [11:0] res_data_o,
	output wire busy_o
);
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_SCAN = 3'b010;
	localparam [2:0] S_WAIT = 3'b100;
	localparam [CW-1:0] LAST = NCH - 1;
	localparam [CW-1:0] ONE = 1;

	reg [2:0] state;
	reg [CW-1:0] chan;

	assign busy_o = ~state[0];

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= S_IDLE;
			chan <= {CW{1'b0}};
			adc_start_o <= 1'b0;
			adc_chan_o <= {CW{1'b0}};
			res_we_o <= 1'b0;
			res_idx_o <= {CW{1'b0}};
			res_data_o <= 12'h000;
		end else begin
			adc_start_o <= 1'b0;
			res_we_o <= 1'b0;
			if (soft_clr_i) begin
				state <= S_IDLE;
				chan <= {CW{1'b0}};
			end else begin
				case (state)
				S_IDLE: begin
					chan <= {CW{1'b0}};
					if ((single_i || cont_i) && (|chan_en_i))
						state <= S_SCAN;
				end
				S_SCAN: begin
					if (chan_en_i[chan]) begin
						adc_start_o <= 1'b1;
						adc_chan_o <= chan;
						state <= S_WAIT;
					end else if (chan == LAST) begin
						chan <= {CW{1'b0}};
						// Repeat only while continuous mode holds
						state <= cont_i ? S_SCAN : S_IDLE;
					end else begin
						chan <= chan + ONE;
					end
				end
				S_WAIT: begin
					if (adc_done_i) begin
						res_we_o <= 1'b1;
						res_idx_o <= chan;
						res_data_o <= adc_data_i;
						if (chan == LAST) begin
							chan <= {CW{1'b0}};
							state <= cont_i ? S_SCAN : S_IDLE;
						end else begin
							chan <= chan + ONE;
							state <= S_SCAN;
						end
					end
				end
				default: state <= S_IDLE;
				endcase
			end
		end
	end
endmodule

// file: hdl/mcr_top.v
// Monitor and controller register bank with conversion and output control
`include "mcr_regs.vh"

module mcr_top #(
	parameter NRES = 17,
	parameter NLIM = 6,
	parameter NOUT = 12,
	parameter NGPIO = 8,
	parameter NFORCE = 4
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// Register access after the serial framing
	input wire [7:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	output wire bus_timeout_disable_o,
	// Converter handshake
	output wire adc_start_o,
	output wire [4:0] adc_chan_o,
	input wire adc_done_i,
	input wire [11:0] adc_data_i,
	output wire adc_busy_o,
	output wire converter_external_ref_o,
	// Output converters
	output wire [NOUT*12-1:0] output_code_o,
	output wire output_external_ref_o,
	input wire [NFORCE-1:0] async_force_input_i,
	output wire [NOUT-1:0] out_force_o,
	output wire forced_level_select_o,
	output wire out_hiz_o,
	// GPIO pulldowns
	output wire [NGPIO-1:0] pulldown_off_o,
	// Open-drain interrupt pins, enable low while pulling
	output wire irq_out_low_group_o,
	output wire irq_out_low_group_oe_n_o,
	output wire irq_out_high_group_o,
	output wire irq_out_high_group_oe_n_o
);
	reg [7:0] general_config;
	reg [7:0] dac_config;
	reg [7:0] gpio_pulldown_control;
	reg [7:0] high_limit_irq_enable;
	reg [7:0] low_limit_irq_enable;
	reg [7:0] channel_enable_first;
	reg [7:0] channel_enable_second;
	reg [7:0] temp_channel_enable;
	reg [7:0] reference_mode;
	reg [11:0] conversion_result [0:NRES-1];
	reg [11:0] upper_window_limit [0:NLIM-1];
	reg [11:0] lower_window_limit [0:NLIM-1];
	reg [11:0] output_code [0:NOUT-1];
	reg [NFORCE-1:0] force_meta;
	reg [NFORCE-1:0] force_sync;
	reg [15:0] next_rdata;

	wire register_lock = general_config[`MCR_GEN_LOCK];
	wire continuous_start = general_config[`MCR_GEN_START];
	wire gen_hit = reg_wr_i && (reg_addr_i == `MCR_ADDR_GEN);
	// Soft reset acts in the write cycle itself; read data and the force synchronisers keep their values
	wire soft_clr = gen_hit && reg_wdata_i[`MCR_GEN_RST];
	wire wr_any = reg_wr_i && !soft_clr;
	wire wr_lockable = wr_any && !register_lock;
	wire bcast_hit = wr_any && (reg_addr_i == `MCR_ADDR_BCAST);
	wire [7:0] res_off = reg_addr_i - `MCR_ADDR_RES_BASE;
	wire [7:0] hlim_off = reg_addr_i - `MCR_ADDR_HLIM_BASE;
	wire [7:0] llim_off = reg_addr_i - `MCR_ADDR_LLIM_BASE;
	wire [7:0] code_off = reg_addr_i - `MCR_ADDR_CODE_BASE;
	// Trigger is an event, not storage; it still needs lock set
	wire single_shot = wr_any && (reg_addr_i == `MCR_ADDR_TRIG) &&
		!continuous_start && register_lock;
	wire cont_run = continuous_start && register_lock;
	wire [NRES-1:0] chan_en = {temp_channel_enable[0],
		channel_enable_second, channel_enable_first};
	wire res_we;
	wire [4:0] res_idx;
	wire [11:0] res_data;
	wire [NLIM-1:0] over_high;
	wire [NLIM-1:0] under_low;

	// Control registers
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			general_config <= `MCR_RST_GEN;
			dac_config <= `MCR_RST_DACCFG;
			gpio_pulldown_control <= `MCR_RST_PULLDN;
			high_limit_irq_enable <= `MCR_RST_IRQEN;
			low_limit_irq_enable <= `MCR_RST_IRQEN;
			channel_enable_first <= `MCR_RST_CHEN;
			channel_enable_second <= `MCR_RST_CHEN;
			temp_channel_enable <= `MCR_RST_CHEN;
			reference_mode <= `MCR_RST_REFMODE;
		end else if (soft_clr) begin
			general_config <= `MCR_RST_GEN;
			dac_config <= `MCR_RST_DACCFG;
			gpio_pulldown_control <= `MCR_RST_PULLDN;
			high_limit_irq_enable <= `MCR_RST_IRQEN;
			low_limit_irq_enable <= `MCR_RST_IRQEN;
			channel_enable_first <= `MCR_RST_CHEN;
			channel_enable_second <= `MCR_RST_CHEN;
			temp_channel_enable <= `MCR_RST_CHEN;
			reference_mode <= `MCR_RST_REFMODE;
		end else begin
			if (gen_hit)
				general_config <= reg_wdata_i[7:0] & `MCR_GEN_MASK;
			if (wr_any && reg_addr_i == `MCR_ADDR_DACCFG)
				dac_config <= reg_wdata_i[7:0] & `MCR_DACCFG_MASK;
			if (wr_any && reg_addr_i == `MCR_ADDR_PULLDN)
				gpio_pulldown_control <= reg_wdata_i[7:0];
			if (wr_any && reg_addr_i == `MCR_ADDR_REFMODE)
				reference_mode <= reg_wdata_i[7:0] & `MCR_REF_MASK;
			if (wr_lockable && reg_addr_i == `MCR_ADDR_HIEN)
				high_limit_irq_enable <=
					reg_wdata_i[7:0] & `MCR_IRQEN_MASK;
			if (wr_lockable && reg_addr_i == `MCR_ADDR_LOEN)
				low_limit_irq_enable <=
					reg_wdata_i[7:0] & `MCR_IRQEN_MASK;
			if (wr_lockable && reg_addr_i == `MCR_ADDR_CHEN1)
				channel_enable_first <= reg_wdata_i[7:0];
			if (wr_lockable && reg_addr_i == `MCR_ADDR_CHEN2)
				channel_enable_second <= reg_wdata_i[7:0];
			if (wr_lockable && reg_addr_i == `MCR_ADDR_TEMPEN)
				temp_channel_enable <=
					reg_wdata_i[7:0] & `MCR_TEMPEN_MASK;
		end
	end

	// Conversion results; enable changes never touch them
	genvar i;
	generate
		for (i = 0; i < NRES; i = i + 1) begin : g_res
			always @(posedge ref_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i)
					conversion_result[i] <= `MCR_RST_RESULT;
				else if (soft_clr)
					conversion_result[i] <= `MCR_RST_RESULT;
				else if (res_we && res_idx == i)
					conversion_result[i] <= res_data;
			end
		end
		// Window limits, lockable, upper bits dropped
		for (i = 0; i < NLIM; i = i + 1) begin : g_lim
			always @(posedge ref_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					upper_window_limit[i] <= `MCR_RST_HLIM;
					lower_window_limit[i] <= `MCR_RST_LLIM;
				end else if (soft_clr) begin
					upper_window_limit[i] <= `MCR_RST_HLIM;
					lower_window_limit[i] <= `MCR_RST_LLIM;
				end else begin
					if (wr_lockable && hlim_off == i)
						upper_window_limit[i] <=
							reg_wdata_i[11:0];
					if (wr_lockable && llim_off == i)
						lower_window_limit[i] <=
							reg_wdata_i[11:0];
				end
			end
			// Unsigned compare of 12-bit codes
			assign over_high[i] = conversion_result[i < 3 ? i : i + 5] >
				upper_window_limit[i];
			assign under_low[i] = conversion_result[i < 3 ? i : i + 5] <=
				lower_window_limit[i];
		end
		// Output codes, each written alone or all by broadcast
		for (i = 0; i < NOUT; i = i + 1) begin : g_code
			always @(posedge ref_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i)
					output_code[i] <= `MCR_RST_CODE;
				else if (soft_clr)
					output_code[i] <= `MCR_RST_CODE;
				else if (bcast_hit)
					output_code[i] <= reg_wdata_i[11:0];
				else if (wr_any && code_off == i)
					output_code[i] <= reg_wdata_i[11:0];
			end
			// Straight from the flops: no staging, immediate update
			assign output_code_o[i*12 +: 12] = output_code[i];
			// Grouping 0: blocks of three per input; 1: blocks of six
			assign out_force_o[i] = dac_config[`MCR_DAC_GROUP] ?
				~force_sync[i / 6] : ~force_sync[i / 3];
		end
	endgenerate

	// Force inputs are asynchronous pins
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			force_meta <= {NFORCE{1'b1}};
			force_sync <= {NFORCE{1'b1}};
		end else begin
			force_meta <= async_force_input_i;
			force_sync <= force_meta;
		end
	end

	mcr_seq #(
		.NCH(NRES),
		.CW(5)
	) u_seq (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.soft_clr_i(soft_clr),
		.single_i(single_shot),
		.cont_i(cont_run),
		.chan_en_i(chan_en),
		.adc_start_o(adc_start_o),
		.adc_chan_o(adc_chan_o),
		.adc_done_i(adc_done_i),
		.adc_data_i(adc_data_i),
		.res_we_o(res_we),
		.res_idx_o(res_idx),
		.res_data_o(res_data),
		.busy_o(adc_busy_o)
	);

	// Read decode; data registers read with bits 15:12 zero
	always @* begin
		next_rdata = 16'h0000;
		if (reg_addr_i >= `MCR_ADDR_RES_BASE &&
			reg_addr_i <= `MCR_ADDR_RES_LAST)
			next_rdata = {4'h0, conversion_result[res_off[4:0]]};
		else if (reg_addr_i >= `MCR_ADDR_HLIM_BASE &&
			reg_addr_i < `MCR_ADDR_LLIM_BASE)
			next_rdata = {4'h0, upper_window_limit[hlim_off[2:0]]};
		else if (reg_addr_i >= `MCR_ADDR_LLIM_BASE &&
			reg_addr_i <= `MCR_ADDR_LIM_LAST)
			next_rdata = {4'h0, lower_window_limit[llim_off[2:0]]};
		else if (reg_addr_i >= `MCR_ADDR_CODE_BASE &&
			reg_addr_i <= `MCR_ADDR_CODE_LAST)
			next_rdata = {4'h0, output_code[code_off[3:0]]};
		else begin
			case (reg_addr_i)
			`MCR_ADDR_GEN: next_rdata = {8'h00, general_config};
			`MCR_ADDR_DACCFG: next_rdata = {8'h00, dac_config};
			`MCR_ADDR_PULLDN: next_rdata = {8'h00, gpio_pulldown_control};
			`MCR_ADDR_HIEN: next_rdata = {8'h00, high_limit_irq_enable};
			`MCR_ADDR_LOEN: next_rdata = {8'h00, low_limit_irq_enable};
			`MCR_ADDR_CHEN1: next_rdata = {8'h00, channel_enable_first};
			`MCR_ADDR_CHEN2: next_rdata = {8'h00, channel_enable_second};
			`MCR_ADDR_TEMPEN: next_rdata = {8'h00, temp_channel_enable};
			`MCR_ADDR_REFMODE: next_rdata = {8'h00, reference_mode};
			default: next_rdata = 16'h0000;
			endcase
		end
	end

	// Read data held until the next read strobe
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_rd_i)
			reg_rdata_o <= next_rdata;
	end

	assign bus_timeout_disable_o = general_config[`MCR_GEN_TOD];
	assign forced_level_select_o = dac_config[`MCR_DAC_LEVEL];
	assign out_hiz_o = dac_config[`MCR_DAC_OFF];
	assign pulldown_off_o = gpio_pulldown_control;
	assign converter_external_ref_o =
		reference_mode[`MCR_REF_ADC_EXT];
	assign output_external_ref_o = reference_mode[`MCR_REF_DAC_EXT];

	// Open-drain, active low: pull only while a group condition stands
	assign irq_out_low_group_o = 1'b0;
	assign irq_out_high_group_o = 1'b0;
	assign irq_out_low_group_oe_n_o =
		~(|((over_high[2:0] & high_limit_irq_enable[2:0]) |
		(under_low[2:0] & low_limit_irq_enable[2:0])));
	assign irq_out_high_group_oe_n_o =
		~(|((over_high[5:3] & high_limit_irq_enable[5:3]) |
		(under_low[5:3] & low_limit_irq_enable[5:3])));
endmodule

// file: dv/mcr_adc_model.sv
// Behavioural converter answering the sequencer start requests
module mcr_adc_model (
	// Clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// Request from the bank
	input wire adc_start_i,
	input wire [4:0] adc_chan_i,
	// Bench knobs: latency and result base
	input wire [3:0] lat_i,
	input wire [11:0] base_i,
	// Answer
	output reg adc_done_o,
	output reg [11:0] adc_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [3:0] cnt;
	reg run;
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			run <= 1'b0;
			cnt <= 4'h0;
			adc_done_o <= 1'b0;
			adc_data_o <= 12'hFFF;
		end else begin
			adc_done_o <= 1'b0;
			// Data is only meaningful with done; toggle it otherwise
			adc_data_o <= ~adc_data_o;
			if (adc_start_i) begin
				run <= 1'b1;
				cnt <= lat_i;
			end else if (run && cnt == 4'h0) begin
				run <= 1'b0;
				adc_done_o <= 1'b1;
				adc_data_o <= base_i + {7'h00, adc_chan_i};
			end else if (run) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule

// file: dv/mcr_top_asserts.sv
// Port-level assertions for the monitor register bank
module mcr_top_asserts #(
	parameter NOUT = 12
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// Register port
	input wire [7:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_rd_i,
	input wire [15:0] reg_rdata_o,
	input wire bus_timeout_disable_o,
	// Converter and outputs
	input wire adc_start_o,
	input wire adc_done_i,
	input wire adc_busy_o,
	input wire [NOUT*12-1:0] output_code_o,
	input wire out_hiz_o,
	input wire forced_level_select_o,
	input wire [7:0] pulldown_off_o
);
	timeunit 1ns;
	timeprecision 1ps;
	reg lock_s;
	reg start_s;
	wire wr_gen = reg_wr_i && reg_addr_i == 8'h14;
	wire trig = reg_wr_i && reg_addr_i == 8'h1C;
	// Mirror of lock and start so refusals can be judged
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lock_s <= 1'b0;
			start_s <= 1'b0;
		end else if (wr_gen) begin
			lock_s <= reg_wdata_i[1] & ~reg_wdata_i[7];
			start_s <= reg_wdata_i[0] & ~reg_wdata_i[7];
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence soft_rst;
		wr_gen && reg_wdata_i[7];
	endsequence
	sequence idle_quiet;
		!adc_busy_o && !start_s && !(trig && lock_s);
	endsequence
	soft_reset_a: assert property (soft_rst |=> out_hiz_o &&
		pulldown_off_o == 8'hFF && output_code_o == '0)
		else $error("soft reset left state");
	tod_bit_a: assert property (wr_gen && !reg_wdata_i[7] |=>
		bus_timeout_disable_o == $past(reg_wdata_i[2]))
		else $error("timeout disable wrong");
	dac_cfg_a: assert property (reg_wr_i && reg_addr_i == 8'h15 |=>
		out_hiz_o == $past(reg_wdata_i[0]) &&
		forced_level_select_o == $past(reg_wdata_i[1]))
		else $error("dac config pins wrong");
	pulldown_a: assert property (reg_wr_i && reg_addr_i == 8'h16 |=>
		pulldown_off_o == $past(reg_wdata_i[7:0]))
		else $error("pulldown pins wrong");
	code_wr_a: assert property (reg_wr_i && reg_addr_i == 8'h80 |=>
		output_code_o[11:0] == $past(reg_wdata_i[11:0]))
		else $error("code not updated");
	bcast_all_a: assert property (reg_wr_i && reg_addr_i == 8'h90 |=>
		output_code_o == {NOUT{$past(reg_wdata_i[11:0])}})
		else $error("broadcast not applied");
	wo_read_a: assert property (reg_rd_i &&
		(reg_addr_i == 8'h1C || reg_addr_i == 8'h90) |=> reg_rdata_o == 16'h0000)
		else $error("write-only read not zero");
	no_go_a: assert property (idle_quiet |=> !adc_busy_o)
		else $error("sequence began unasked");
	start_pulse_a: assert property (adc_start_o |=> !adc_start_o)
		else $error("start longer than one cycle");
	busy_start_a: assert property (adc_start_o |-> adc_busy_o)
		else $error("start without busy");
	done_next_a: assert property (adc_done_i && adc_busy_o |->
		##[1:20] (adc_start_o || !adc_busy_o))
		else $error("sequencer stalled");
endmodule
bind mcr_top mcr_top_asserts #(.NOUT(NOUT)) mcr_top_asserts_inst (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .bus_timeout_disable_o(bus_timeout_disable_o),
	.adc_start_o(adc_start_o), .adc_done_i(adc_done_i),
	.adc_busy_o(adc_busy_o), .output_code_o(output_code_o),
	.out_hiz_o(out_hiz_o), .forced_level_select_o(forced_level_select_o),
	.pulldown_off_o(pulldown_off_o)
);

// file: dv/tb_top.sv
// Self-checking bench for the monitor register bank
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	reg ref_clk_i = 1'b0;
	reg sys_rst_i = 1'b1;
	reg [7:0] reg_addr_i = 8'h00;
	reg reg_wr_i = 1'b0;
	reg [15:0] reg_wdata_i = 16'h0000;
	reg reg_rd_i = 1'b0;
	reg [3:0] async_force_input_i = 4'hF;
	reg [3:0] lat = 4'h0;
	reg [11:0] base = 12'h300;
	wire [15:0] reg_rdata_o;
	wire adc_start_o, adc_done_i, adc_busy_o, hiz, lvl, ilo, ihi;
	wire bus_timeout_disable, aref, dref;
	wire [4:0] adc_chan_o;
	wire [11:0] adc_data_i;
	wire [11:0] force_o;
	wire [143:0] code;
	wire [7:0] pd;
	int n_fail = 0;
	int n_checks = 0;
	int starts = 0;
	int n;
	logic [4:0] chq[$];
	logic [4:0] expch[5] = '{5'h00, 5'h07, 5'h09, 5'h0E, 5'h10};
	logic [23:0] rst_rows[9] = '{{8'h14, 16'h0000}, {8'h15, 16'h0003},
		{8'h16, 16'h00FF}, {8'h17, 16'h0000}, {8'h40, 16'h0FFF},
		{8'h46, 16'h0000}, {8'h66, 16'h0007}, {8'h20, 16'h0000},
		{8'h80, 16'h0000}};
	logic [39:0] rows[14] = '{{8'h15, 16'h0006, 16'h0006},
		{8'h16, 16'h00A5, 16'h00A5}, {8'h17, 16'h003F, 16'h003F},
		{8'h18, 16'h0001, 16'h0001}, {8'h19, 16'h0081, 16'h0081},
		{8'h1A, 16'h0042, 16'h0042}, {8'h1B, 16'h0001, 16'h0001},
		{8'h66, 16'h0003, 16'h0003}, {8'h40, 16'hF123, 16'h0123},
		{8'h4B, 16'hFFFF, 16'h0FFF}, {8'h80, 16'hFABC, 16'h0ABC},
		{8'h1C, 16'h0001, 16'h0000}, {8'h20, 16'h0FFF, 16'h0000},
		{8'h55, 16'hFFFF, 16'h0000}};
	mcr_top mcr_top_inst (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .bus_timeout_disable_o(bus_timeout_disable),
		.adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
		.adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
		.adc_busy_o(adc_busy_o), .converter_external_ref_o(aref),
		.output_code_o(code), .output_external_ref_o(dref),
		.async_force_input_i(async_force_input_i),
		.out_force_o(force_o), .forced_level_select_o(lvl),
		.out_hiz_o(hiz), .pulldown_off_o(pd),
		.irq_out_low_group_o(), .irq_out_low_group_oe_n_o(ilo),
		.irq_out_high_group_o(), .irq_out_high_group_oe_n_o(ihi)
	);
	mcr_adc_model mcr_adc_model_inst (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.adc_start_i(adc_start_o), .adc_chan_i(adc_chan_o),
		.lat_i(lat), .base_i(base),
		.adc_done_o(adc_done_i), .adc_data_o(adc_data_i)
	);
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Start pulses are one cycle wide, so sample mid-cycle
	always @(negedge ref_clk_i) begin
		if (adc_start_o === 1'b1) begin
			starts++;
			chq.push_back(adc_chan_o);
		end
	end
	task chk(input string nm, input [15:0] e, input [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input [7:0] a, input [15:0] v);
		@(negedge ref_clk_i);
		reg_addr_i = a;
		reg_wdata_i = v;
		reg_wr_i = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask
	task rd(input [7:0] a, input [15:0] e);
		@(negedge ref_clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		chk($sformatf("read %h", a), e, reg_rdata_o);
	endtask
	task wait_idle;
		for (int i = 0; i < 300 && adc_busy_o !== 1'b0; i++)
			@(negedge ref_clk_i);
		chk("busy", 16'h0000, {15'h0, adc_busy_o});
	endtask
	task chk_reset;
		foreach (rst_rows[i])
			rd(rst_rows[i][23:16], rst_rows[i][15:0]);
		chk("hiz", 16'h0001, {15'h0, hiz});
		chk("pulldown", 16'h00FF, {8'h00, pd});
		chk("irq low", 16'h0001, {15'h0, ilo});
		chk("refs", 16'h0003, {14'h0, aref, dref});
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		repeat (6) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		chk_reset();
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i][39:32], rows[i][31:16]);
			rd(rows[i][39:32], rows[i][15:0]);
		end
		chk("refs", 16'h0001, {14'h0, aref, dref});
		$display("test rows done");
		wr(8'h14, 16'h0006);
		chk("timeout off", 16'h0001, {15'h0, bus_timeout_disable});
		wr(8'h17, 16'h0000);
		rd(8'h17, 16'h003F);
		wr(8'h40, 16'h0000);
		rd(8'h40, 16'h0123);
		wr(8'h15, 16'h0004);
		rd(8'h15, 16'h0004);
		$display("test lock done");
		wr(8'h1C, 16'h0000);
		wait_idle();
		chk("starts", 16'h0005, chq.size());
		foreach (expch[i]) begin
			chk("chan", {11'h0, expch[i]}, {11'h0, chq[i]});
			rd(8'h20 + expch[i], {4'h0, base} + expch[i]);
		end
		rd(8'h21, 16'h0000);
		chk("irq low", 16'h0000, {15'h0, ilo});
		chk("irq high", 16'h0001, {15'h0, ihi});
		wr(8'h14, 16'h0000);
		wr(8'h19, 16'h0000);
		rd(8'h20, 16'h0300);
		// Channel 8 never converted, so it sits at its low limit
		wr(8'h18, 16'h0008);
		chk("irq high", 16'h0000, {15'h0, ihi});
		$display("test single done");
		wr(8'h19, 16'h0001);
		lat = 4'h9;
		base = 12'hABC;
		starts = 0;
		wr(8'h14, 16'h0001);
		repeat (40) @(negedge ref_clk_i);
		chk("unlocked run", 16'h0000, starts[15:0]);
		wr(8'h14, 16'h0003);
		repeat (100) @(negedge ref_clk_i);
		chk("repeat", 16'h0001, {15'h0, starts > 2});
		wr(8'h14, 16'h0002);
		wait_idle();
		n = starts;
		repeat (40) @(negedge ref_clk_i);
		chk("stopped", n[15:0], starts[15:0]);
		rd(8'h20, 16'h0ABC);
		$display("test continuous done");
		wr(8'h90, 16'hF5A5);
		for (int k = 0; k < 12; k++)
			chk("code", 16'h05A5, {4'h0, code[k*12 +: 12]});
		rd(8'h8B, 16'h05A5);
		async_force_input_i = 4'hE;
		repeat (4) @(negedge ref_clk_i);
		chk("force", 16'h003F, {4'h0, force_o});
		wr(8'h15, 16'h0002);
		chk("force", 16'h0007, {4'h0, force_o});
		chk("level", 16'h0001, {15'h0, lvl});
		async_force_input_i = 4'hF;
		$display("test outputs done");
		wr(8'h14, 16'h0080);
		chk_reset();
		wr(8'h16, 16'h0000);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		chk("pulldown", 16'h00FF, {8'h00, pd});
		$display("test resets done");
		tally_and_finish();
	end
endmodule
